// >>> rtl/pols_sequencer.sv
// power-on reset, undervoltage lockout and register lock sequencer with wishbone slave
`timescale 1ns/1ps
`include "pols_regs.svh"

module pols_sequencer
  import pols_pkg::*;
#(
  parameter int unsigned RELEASE_CYC = `POLS_RELEASE_CYC,
  parameter int unsigned ENGAGE_CYC = `POLS_ENGAGE_CYC,
  parameter int unsigned DISENGAGE_CYC = `POLS_DISENGAGE_CYC,
  parameter int unsigned TIMEOUT_CYC = `POLS_TIMEOUT_CYC
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic above_reset_rising_i,
  input wire logic above_reset_falling_i,
  input wire logic above_lockout_upper_i,
  input wire logic above_lockout_lower_i,
  input wire pols_wb_req_t wb_req_i,
  output pols_wb_rsp_t wb_rsp_o,
  output logic internal_reset_o,
  output pols_out_t out_state_o,
  output logic [`POLS_TRIP_W-1:0] positive_trip_level_o,
  output logic [`POLS_TRIP_W-1:0] negative_trip_level_o,
  output logic [`POLS_ZERO_W-1:0] zero_field_output_code_o,
  output logic irq_o
);

  localparam logic [`POLS_CNT_W-1:0] REL_LAST = `POLS_CNT_W'(RELEASE_CYC - 1);
  localparam logic [`POLS_CNT_W-1:0] ENG_LAST = `POLS_CNT_W'(ENGAGE_CYC - 1);
  localparam logic [`POLS_CNT_W-1:0] DIS_LAST = `POLS_CNT_W'(DISENGAGE_CYC - 1);
  localparam logic [`POLS_CNT_W-1:0] TMO_LAST = `POLS_CNT_W'(TIMEOUT_CYC - 1);

  // ----------------------------------------------------------------
  // comparator synchronisers
  // ----------------------------------------------------------------
  logic [3:0] cmp_meta_q;
  logic [3:0] cmp_q;
  logic porh_s;
  logic porl_s;
  logic uvloh_s;
  logic uvlol_s;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cmp_meta_q <= 4'h0;
      cmp_q <= 4'h0;
    end else if (clk_en_i) begin
      cmp_meta_q <= {above_reset_rising_i, above_reset_falling_i, above_lockout_upper_i, above_lockout_lower_i};
      cmp_q <= cmp_meta_q;
    end
  end

  assign porh_s = cmp_q[3];
  assign porl_s = cmp_q[2];
  assign uvloh_s = cmp_q[1];
  assign uvlol_s = cmp_q[0];

  // ----------------------------------------------------------------
  // supply sequencing
  // ----------------------------------------------------------------
  pols_state_t state_q;
  pols_state_t state_d;
  logic [`POLS_CNT_W-1:0] cnt_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RESET: begin
        if (porh_s) state_d = ST_REL_WAIT;
      end
      ST_REL_WAIT: begin
        if (cnt_q == REL_LAST && uvloh_s) state_d = ST_POWER_WAIT;
      end
      ST_POWER_WAIT: begin
        if (cnt_q == DIS_LAST) state_d = ST_NORMAL;
      end
      ST_NORMAL: begin
        if (!uvlol_s) state_d = ST_ENGAGE;
      end
      ST_ENGAGE: begin
        if (uvlol_s) state_d = ST_NORMAL;
        else if (cnt_q == ENG_LAST) state_d = ST_LOCKOUT;
      end
      ST_LOCKOUT: begin
        if (uvloh_s) state_d = ST_RECOVER;
      end
      ST_RECOVER: begin
        if (!uvloh_s) state_d = ST_LOCKOUT;
        else if (cnt_q == DIS_LAST) state_d = ST_NORMAL;
      end
      default: state_d = ST_RESET;
    endcase
    if (!porl_s) state_d = ST_RESET;
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= ST_RESET;
    end else if (clk_en_i) begin
      state_q <= state_d;
    end
  end

  // shared delay counter, restarts on every state change
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q <= '0;
    end else if (clk_en_i) begin
      if (state_d != state_q) cnt_q <= '0;
      else if (state_q == ST_REL_WAIT && cnt_q == REL_LAST) cnt_q <= cnt_q;
      else cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      internal_reset_o <= 1'b1;
      out_state_o <= OUT_HIZ;
    end else if (clk_en_i) begin
      internal_reset_o <= (state_d == ST_RESET || state_d == ST_REL_WAIT);
      case (state_d)
        ST_NORMAL, ST_ENGAGE: out_state_o <= OUT_NORMAL;
        ST_LOCKOUT, ST_RECOVER: out_state_o <= OUT_LOW;
        default: out_state_o <= OUT_HIZ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // access lock
  // ----------------------------------------------------------------
  logic [`POLS_CNT_W-1:0] tmo_q;
  logic tmo_done_q;
  logic unlocked_q;
  logic perm_bit_q;
  logic perm_active_q;
  logic wr_req;
  logic rd_req;
  logic unlock_hit;
  logic mem_adr;
  logic refused;

  assign wr_req = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && !wb_rsp_o.ack;
  assign rd_req = wb_req_i.cyc && wb_req_i.stb && !wb_req_i.we && !wb_rsp_o.ack;
  assign mem_adr = wb_req_i.adr == `POLS_ADR_LOCK_CTRL || wb_req_i.adr == `POLS_ADR_FAULT_THR ||
                   wb_req_i.adr == `POLS_ADR_ZERO_CODE;
  assign unlock_hit = wr_req && wb_req_i.adr == `POLS_ADR_UNLOCK && wb_req_i.sel == 4'hf &&
                      wb_req_i.dat[`POLS_CODE_W-1:0] == `POLS_CUSTOMER_CODE &&
                      !tmo_done_q && !perm_active_q && state_q != ST_RESET;
  assign refused = !unlocked_q && (wr_req || rd_req) && mem_adr;

  // timeout measured from the rising reset threshold crossing
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tmo_q <= '0;
      tmo_done_q <= 1'b0;
    end else if (clk_en_i) begin
      if (state_q == ST_RESET) begin
        tmo_q <= '0;
        tmo_done_q <= 1'b0;
      end else if (!tmo_done_q) begin
        tmo_q <= tmo_q + 1'b1;
        tmo_done_q <= (tmo_q == TMO_LAST);
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      unlocked_q <= 1'b0;
    end else if (clk_en_i) begin
      if (state_q == ST_RESET || perm_active_q) unlocked_q <= 1'b0;
      else if (unlock_hit) unlocked_q <= 1'b1;
    end
  end

  // permanent bit is cleared only by reset_n_i, never by a write; it only takes effect after a power cycle
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      perm_active_q <= 1'b0;
    end else if (clk_en_i && state_q == ST_RESET) begin
      perm_active_q <= perm_bit_q;
    end
  end

  // ----------------------------------------------------------------
  // memory registers
  // ----------------------------------------------------------------
  logic [`POLS_FAULT_W-1:0] fault_threshold_code_q;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      perm_bit_q <= 1'b0;
      fault_threshold_code_q <= `POLS_FAULT_RST;
      zero_field_output_code_o <= `POLS_ZERO_RST;
    end else if (clk_en_i && wr_req && unlocked_q) begin
      if (wb_req_i.adr == `POLS_ADR_LOCK_CTRL && wb_req_i.sel[0] && wb_req_i.dat[`POLS_PERM_LOCK_BIT]) begin
        perm_bit_q <= 1'b1;
      end
      if (wb_req_i.adr == `POLS_ADR_FAULT_THR && wb_req_i.sel[0]) begin
        fault_threshold_code_q <= wb_req_i.dat[`POLS_FAULT_W-1:0];
      end
      if (wb_req_i.adr == `POLS_ADR_ZERO_CODE) begin
        if (wb_req_i.sel[0]) zero_field_output_code_o[7:0] <= wb_req_i.dat[7:0];
        if (wb_req_i.sel[1]) zero_field_output_code_o[8] <= wb_req_i.dat[8];
      end
    end
  end

  // both trip levels from one code, fractions summing to full scale
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      positive_trip_level_o <= `POLS_TRIP_W'(`POLS_FAULT_RST);
      negative_trip_level_o <= `POLS_TRIP_FULL - `POLS_TRIP_W'(`POLS_FAULT_RST);
    end else if (clk_en_i) begin
      positive_trip_level_o <= {1'b0, fault_threshold_code_q};
      negative_trip_level_o <= `POLS_TRIP_FULL - {1'b0, fault_threshold_code_q};
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  logic [`POLS_IRQ_W-1:0] irq_stat_q;
  logic [`POLS_IRQ_W-1:0] irq_en_q;
  logic [`POLS_IRQ_W-1:0] irq_evt;
  logic [`POLS_IRQ_W-1:0] irq_clr;

  always_comb begin
    irq_evt = '0;
    irq_evt[`POLS_IRQ_UNLOCK] = unlock_hit && !unlocked_q;
    irq_evt[`POLS_IRQ_RELEASE] = state_q == ST_REL_WAIT && state_d == ST_POWER_WAIT;
    irq_evt[`POLS_IRQ_LOCKOUT] = state_q == ST_ENGAGE && state_d == ST_LOCKOUT;
    irq_evt[`POLS_IRQ_REFUSED] = refused;
    irq_clr = '0;
    if (wr_req && wb_req_i.adr == `POLS_ADR_IRQ_CLR && wb_req_i.sel[0]) begin
      irq_clr = wb_req_i.dat[`POLS_IRQ_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_stat_q <= '0;
      irq_en_q <= '0;
      irq_o <= 1'b0;
    end else if (clk_en_i) begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_evt;
      if (wr_req && wb_req_i.adr == `POLS_ADR_IRQ_EN && wb_req_i.sel[0]) begin
        irq_en_q <= wb_req_i.dat[`POLS_IRQ_W-1:0];
      end
      irq_o <= |(((irq_stat_q & ~irq_clr) | irq_evt) & irq_en_q);
    end
  end

  // ----------------------------------------------------------------
  // wishbone answer, one cycle after the request
  // ----------------------------------------------------------------
  logic [31:0] rd_dat;

  always_comb begin
    rd_dat = 32'h0;
    case (wb_req_i.adr)
      `POLS_ADR_STATUS: rd_dat = {23'h0, tmo_done_q, perm_active_q, unlocked_q, internal_reset_o,
                                  out_state_o, state_q};
      `POLS_ADR_LOCK_CTRL: rd_dat = {31'h0, perm_bit_q};
      `POLS_ADR_FAULT_THR: rd_dat = {26'h0, fault_threshold_code_q};
      `POLS_ADR_ZERO_CODE: rd_dat = {23'h0, zero_field_output_code_o};
      `POLS_ADR_IRQ_STAT: rd_dat = {28'h0, irq_stat_q};
      `POLS_ADR_IRQ_EN: rd_dat = {28'h0, irq_en_q};
      default: rd_dat = 32'h0;
    endcase
    if (!unlocked_q && mem_adr) rd_dat = 32'h0;
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wb_rsp_o <= '0;
    end else if (clk_en_i) begin
      wb_rsp_o.ack <= wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
      if (rd_req) wb_rsp_o.dat <= rd_dat;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_engage_started;
    clk_en_i && state_q == ST_NORMAL && !uvlol_s && porl_s;
  endsequence

  sequence s_cancelled;
    clk_en_i && state_q == ST_ENGAGE && uvlol_s && porl_s;
  endsequence

  property p_hiz_in_reset;
    internal_reset_o |-> out_state_o == OUT_HIZ;
  endproperty
  a_hiz_in_reset: assert property (p_hiz_in_reset) else $error("output not hiz during reset");

  property p_por_fall;
    clk_en_i && !porl_s |=> state_q == ST_RESET ##0 internal_reset_o && out_state_o == OUT_HIZ;
  endproperty
  a_por_fall: assert property (p_por_fall) else $error("no reset on supply fall");

  property p_release;
    clk_en_i && state_q == ST_REL_WAIT && state_d == ST_POWER_WAIT |-> cnt_q == REL_LAST && uvloh_s;
  endproperty
  a_release: assert property (p_release) else $error("reset released early");

  property p_lockout_low;
    state_q == ST_LOCKOUT |-> out_state_o == OUT_LOW;
  endproperty
  a_lockout_low: assert property (p_lockout_low) else $error("lockout not driving low");

  property p_engage;
    clk_en_i && state_q == ST_ENGAGE && state_d == ST_LOCKOUT |-> cnt_q == ENG_LAST && !uvlol_s;
  endproperty
  a_engage: assert property (p_engage) else $error("lockout engaged early");

  property p_disengage;
    clk_en_i && state_q == ST_RECOVER && state_d == ST_NORMAL |-> cnt_q == DIS_LAST && uvloh_s;
  endproperty
  a_disengage: assert property (p_disengage) else $error("lockout left early");

  property p_engage_begin;
    s_engage_started |=> state_q == ST_ENGAGE && out_state_o == OUT_NORMAL;
  endproperty
  a_engage_begin: assert property (p_engage_begin) else $error("lockout count not started");

  property p_cancel;
    s_cancelled |=> state_q == ST_NORMAL && out_state_o == OUT_NORMAL;
  endproperty
  a_cancel: assert property (p_cancel) else $error("lockout entry not cancelled");

  property p_trip_sum;
    positive_trip_level_o + negative_trip_level_o == `POLS_TRIP_FULL;
  endproperty
  a_trip_sum: assert property (p_trip_sum) else $error("trip levels not complementary");

  property p_relock;
    clk_en_i && state_q == ST_RESET |=> !unlocked_q;
  endproperty
  a_relock: assert property (p_relock) else $error("lock not restored at power-up");

  property p_unlock_in_time;
    $rose(unlocked_q) |-> !$past(tmo_done_q) && $past(state_q) != ST_RESET && !$past(perm_active_q);
  endproperty
  a_unlock_in_time: assert property (p_unlock_in_time) else $error("unlock outside window");

  property p_perm;
    perm_active_q |=> !unlocked_q;
  endproperty
  a_perm: assert property (p_perm) else $error("access open under permanent lock");

  property p_locked_read;
    clk_en_i && rd_req && mem_adr && !unlocked_q |=> wb_rsp_o.ack && wb_rsp_o.dat == 32'h0;
  endproperty
  a_locked_read: assert property (p_locked_read) else $error("locked read returned data");

endmodule

// >>> rtl/pols_regs.svh
// register offsets, field positions, reset values and timing counts of the power-on lock sequencer
`ifndef POLS_REGS_SVH
`define POLS_REGS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define POLS_ADR_STATUS 8'h00
`define POLS_ADR_LOCK_CTRL 8'h04
`define POLS_ADR_FAULT_THR 8'h08
`define POLS_ADR_ZERO_CODE 8'h0c
`define POLS_ADR_IRQ_STAT 8'h10
`define POLS_ADR_IRQ_CLR 8'h14
`define POLS_ADR_IRQ_EN 8'h18
`define POLS_ADR_UNLOCK 8'h24

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define POLS_PERM_LOCK_BIT 0
`define POLS_FAULT_W 6
`define POLS_ZERO_W 9
`define POLS_CODE_W 30
`define POLS_TRIP_W 7
`define POLS_TRIP_FULL 7'h40
`define POLS_FAULT_RST 6'h20
`define POLS_ZERO_RST 9'h100
`define POLS_IRQ_W 4
`define POLS_IRQ_UNLOCK 0
`define POLS_IRQ_RELEASE 1
`define POLS_IRQ_LOCKOUT 2
`define POLS_IRQ_REFUSED 3
// arbitrary value, not tied to any real part
`define POLS_CUSTOMER_CODE 30'h1a5c_3e71

// ----------------------------------------------------------------
// timing: figures in their own unit, cycles derived from the clock
// ----------------------------------------------------------------
`define POLS_CLK_PERIOD_PS 5000
`define POLS_RELEASE_NS 20000
`define POLS_ENGAGE_US 64
`define POLS_DISENGAGE_NS 10000
`define POLS_TIMEOUT_MS 8
`define POLS_RELEASE_CYC ((`POLS_RELEASE_NS * 1000 + `POLS_CLK_PERIOD_PS - 1) / `POLS_CLK_PERIOD_PS)
`define POLS_ENGAGE_CYC ((`POLS_ENGAGE_US * 1000000 + `POLS_CLK_PERIOD_PS - 1) / `POLS_CLK_PERIOD_PS)
`define POLS_DISENGAGE_CYC ((`POLS_DISENGAGE_NS * 1000 + `POLS_CLK_PERIOD_PS - 1) / `POLS_CLK_PERIOD_PS)
`define POLS_TIMEOUT_CYC (`POLS_TIMEOUT_MS * (1000000000 / `POLS_CLK_PERIOD_PS))
`define POLS_CNT_W 21

`endif

// >>> rtl/pols_pkg.sv
// types of the power-on lock sequencer
package pols_pkg;

  typedef enum logic [2:0] {
    ST_RESET      = 3'b000,
    ST_REL_WAIT   = 3'b001,
    ST_POWER_WAIT = 3'b010,
    ST_NORMAL     = 3'b011,
    ST_ENGAGE     = 3'b100,
    ST_LOCKOUT    = 3'b101,
    ST_RECOVER    = 3'b110
  } pols_state_t;

  typedef enum logic [1:0] {
    OUT_HIZ    = 2'b00,
    OUT_LOW    = 2'b01,
    OUT_NORMAL = 2'b10
  } pols_out_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } pols_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } pols_wb_rsp_t;

endpackage

// >>> tb/pols_supply_model.sv
// supply comparator model standing in for the programmer's supply pin
`timescale 1ns/1ps

module pols_supply_model (
  input wire logic [2:0] level_i,
  output logic above_reset_falling_o,
  output logic above_reset_rising_o,
  output logic above_lockout_lower_o,
  output logic above_lockout_upper_o
);
  // ----------------------------------------------------------------
  // threshold ladder: 0 off, 1 falling reset, 2 rising reset, 3 lower, 4 upper
  // ----------------------------------------------------------------
  // thresholds nest, so a higher supply level sets every comparator below it
  assign above_reset_falling_o = (level_i >= 3'd1);
  assign above_reset_rising_o = (level_i >= 3'd2);
  assign above_lockout_lower_o = (level_i >= 3'd3);
  assign above_lockout_upper_o = (level_i >= 3'd4);
endmodule

// >>> tb/test_pols_sequencer.sv
// self-checking bench of the power-on lock sequencer
`timescale 1ns/1ps
`include "pols_regs.svh"

module test_pols_sequencer
  import pols_pkg::*;
;
  localparam int REL = 8;
  localparam int ENG = 16;
  localparam int DIS = 8;
  localparam int TMO = 200;
  logic ref_clk_i, reset_n_i, irst, irq, cf, cr, cl, cu;
  logic clk_en;
  logic [2:0] level;
  logic [5:0] fc;
  logic [8:0] zc, zcode;
  logic [6:0] ptrip, ntrip;
  logic [32:0] note;
  logic [2:0] cur, prev;
  pols_wb_req_t req;
  pols_wb_rsp_t rsp;
  pols_out_t ost;
  logic [32:0] rd_q[$];
  logic [2:0] st_q[$];
  int fail_count, total_checks, seed;

  pols_supply_model u_supply (.level_i(level), .above_reset_falling_o(cf), .above_reset_rising_o(cr),
    .above_lockout_lower_o(cl), .above_lockout_upper_o(cu));
  pols_sequencer #(.RELEASE_CYC(REL), .ENGAGE_CYC(ENG), .DISENGAGE_CYC(DIS), .TIMEOUT_CYC(TMO)) DUT (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en), .above_reset_rising_i(cr),
    .above_reset_falling_i(cf), .above_lockout_upper_i(cu), .above_lockout_lower_i(cl), .wb_req_i(req),
    .wb_rsp_o(rsp), .internal_reset_o(irst), .out_state_o(ost), .positive_trip_level_o(ptrip),
    .negative_trip_level_o(ntrip), .zero_field_output_code_o(zcode), .irq_o(irq));

  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end

  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scoreboard: bus answers and output state changes
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i) begin
    if (rsp.ack === 1'b1) begin
      if (rd_q.size() == 0) begin
        chk(32'h1, 32'h0, "unexpected ack");
      end else begin
        note = rd_q.pop_front();
        if (note[32]) chk(rsp.dat, note[31:0], "read data");
      end
    end
    cur = {irst, ost};
    if (reset_n_i === 1'b1 && cur !== prev) begin
      if (st_q.size() == 0) chk(32'(cur), 32'(prev), "unexpected output change");
      else chk(32'(cur), 32'(st_q.pop_front()), "output state");
    end
    prev = cur;
  end

  // ----------------------------------------------------------------
  // stimulus tasks
  // ----------------------------------------------------------------
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [31:0] exp);
    int n;
    n = 0;
    rd_q.push_back({~we, exp});
    @(posedge ref_clk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
    @(posedge ref_clk_i);
    while (rsp.ack !== 1'b1 && n < 20) begin
      @(posedge ref_clk_i);
      n++;
    end
    if (n >= 20) chk(32'(n), 32'h0, "ack wait");
    req <= '0;
    @(posedge ref_clk_i);
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    wb(1'b1, adr, dat, 32'h0);
  endtask

  task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0, exp);
  endtask

  task automatic hold(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  task automatic set_lvl(input logic [2:0] v);
    @(posedge ref_clk_i);
    level <= v;
  endtask

  task automatic wait_out(input logic r, input pols_out_t o, input int lo, input int hi);
    int n;
    n = 0;
    st_q.push_back({r, o});
    while ({irst, ost} !== {r, o} && n <= hi) begin
      @(posedge ref_clk_i);
      n++;
    end
    if (n < lo || n > hi) chk(32'(n), 32'(lo), "transition time");
  endtask

  task automatic power_up(input bit slow);
    if (slow) begin
      set_lvl(3'd3);
      hold(30);
    end
    set_lvl(3'd4);
    wait_out(1'b0, OUT_HIZ, slow ? 1 : REL, slow ? 6 : REL + 6);
    wait_out(1'b0, OUT_NORMAL, DIS, DIS + 3);
  endtask

  task automatic power_down();
    set_lvl(3'd0);
    wait_out(1'b1, OUT_HIZ, 1, 6);
  endtask

  task automatic unlock();
    wr(8'h24, {2'b00, `POLS_CUSTOMER_CODE});
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    fail_count++;
    $display("Error at %0t: watchdog expired", $time);
    stop_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    fail_count = 0;
    total_checks = 0;
    seed = $urandom(38760);
    req = '0;
    clk_en = 1'b1;
    level = 3'd0;
    reset_n_i = 1'b0;
    prev = 3'b100;
    repeat (4) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    power_up(1'b0);
    $display("test power up done");
    rd(8'h10, 32'h2);
    wr(8'h18, 32'h2);
    hold(2);
    chk(32'(irq), 32'h1, "irq raised");
    wr(8'h14, 32'h2);
    hold(2);
    chk(32'(irq), 32'h0, "irq cleared");
    rd(8'h10, 32'h0);
    wr(8'h18, 32'h8);
    rd(8'h0c, 32'h0);
    wr(8'h08, 32'h11);
    hold(2);
    chk(32'(irq), 32'h1, "refused access irq");
    chk(32'(ptrip), 32'h20, "locked trip");
    wr(8'h14, 32'h8);
    wr(8'h18, 32'h0);
    rd(8'h3c, 32'h0);
    hold(2);
    chk(32'(irq), 32'h0, "irq masked");
    $display("test lock and irq done");
    set_lvl(3'd2);
    hold(ENG - 4);
    set_lvl(3'd4);
    hold(ENG + 8);
    set_lvl(3'd2);
    wait_out(1'b0, OUT_LOW, ENG, ENG + 6);
    set_lvl(3'd3);
    hold(20);
    set_lvl(3'd4);
    wait_out(1'b0, OUT_NORMAL, DIS, DIS + 6);
    $display("test lockout done");
    wr(8'h24, {2'b00, `POLS_CUSTOMER_CODE ^ 30'h1});
    rd(8'h0c, 32'h0);
    unlock();
    rd(8'h0c, 32'h100);
    for (int i = 0; i < 4; i++) begin
      fc = (i == 0) ? 6'h00 : (i == 1) ? 6'h3f : 6'($urandom);
      wr(8'h08, {26'h0, fc});
      hold(2);
      chk(32'(ptrip), 32'({1'b0, fc}), "positive trip");
      chk(32'(ntrip), 32'(7'h40 - {1'b0, fc}), "negative trip");
    end
    zc = 9'($urandom);
    wr(8'h0c, {23'h0, zc});
    rd(8'h0c, {23'h0, zc});
    hold(2);
    chk(32'(zcode), 32'(zc), "zero code output");
    $display("test unlock done");
    // frozen block must ignore a supply dip entirely
    clk_en <= 1'b0;
    set_lvl(3'd0);
    hold(ENG);
    set_lvl(3'd4);
    hold(2);
    clk_en <= 1'b1;
    hold(ENG + 8);
    chk(32'(ost), 32'(OUT_NORMAL), "frozen state");
    $display("test clock enable done");
    power_down();
    power_up(1'b1);
    rd(8'h0c, 32'h0);
    unlock();
    wr(8'h04, 32'h1);
    power_down();
    power_up(1'b0);
    unlock();
    rd(8'h0c, 32'h0);
    rd(8'h08, 32'h0);
    $display("test permanent lock done");
    power_down();
    reset_n_i <= 1'b0;
    hold(2);
    reset_n_i <= 1'b1;
    power_up(1'b0);
    hold(TMO);
    unlock();
    rd(8'h0c, 32'h0);
    $display("test late unlock done");
    stop_test();
  end
endmodule
